// >>> design/ssw_defs.vh
// Shared constants for the supply supervisor and watchdog
`ifndef SSW_DEFS_VH
`define SSW_DEFS_VH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSW_CLK_HZ 40000000
`define SSW_RST_PULSE_MS 200
`define SSW_RST_MIN_MS 140
`define SSW_WD_LONG_MS 1600
`define SSW_WD_SHORT_MS 100
`define SSW_RST_CYC ((`SSW_CLK_HZ / 1000) * `SSW_RST_PULSE_MS)
`define SSW_WD_LONG_CYC ((`SSW_CLK_HZ / 1000) * `SSW_WD_LONG_MS)
`define SSW_WD_SHORT_CYC ((`SSW_CLK_HZ / 1000) * `SSW_WD_SHORT_MS)
`define SSW_EXT_DIV 64
`define SSW_EXT_RST_TICKS 1024
`define SSW_EXT_WD_TICKS 16384
`define SSW_EXT_WD_LONG_TICKS 16384
`endif

// >>> design/ssw_sync.v
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module ssw_sync #(
   parameter WIDTH = 3,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input wire sys_clk,
   input wire resetn,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1;
   // Stage one feeds stage two only
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         stage1 <= INIT;
         sync_out <= INIT;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule
`default_nettype wire

// >>> design/ssw_tick.v
// Tick generator: divides the external timebase clock into watchdog ticks
`timescale 1ns/10ps
`default_nettype none
module ssw_tick #(
   parameter DIV = 64
) (
   input wire sys_clk,
   input wire resetn,
   input wire ext_level,
   output reg ext_tick
);
   reg prev;
   reg [6:0] div_cnt;
   wire rise;
   assign rise = ext_level & ~prev;
   // Divide external rising edges by DIV; one divided period of phase slip
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         prev <= 1'b0;
         div_cnt <= 7'h00;
         ext_tick <= 1'b0;
      end else begin
         prev <= ext_level;
         ext_tick <= 1'b0;
         if (rise) begin
            if (div_cnt == DIV[6:0] - 7'h01) begin
               div_cnt <= 7'h00;
               ext_tick <= 1'b1;
            end else begin
               div_cnt <= div_cnt + 7'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> design/ssw_top.v
// Supply supervisor: reset pulse, watchdog, chip-enable gate, status
// How it works
// [R1] Active-low reset goes low while supply is under threshold or battery.
// [R2] Reset stays low for the pulse time after supply recovers.
// [R3] Watchdog expiry gives a reset pulse, repeating each timeout.
// [R4] Active-high reset is always the inverse of the active-low one.
// [R5] Low-line follows the supply comparator with no stretching.
// [R6] Kick level held past timeout drives reset and expiry low.
// [R7] Floating kick input disables the watchdog; host floats it if unused.
// [R8] Each kick transition restarts the count; host kicks often enough.
// [R9] Expiry flag returns high on a kick edge or when low-line falls.
// [R10] Chip-enable passes when supply good, forced high otherwise.
// [R11] Select high or floating picks internal timing; low picks external.
// [R12] Internal timing uses a fixed 200 ms reset pulse.
// [R13] Internal timing: timebase input level picks 1.6 s or 100 ms.
// [R14] First watchdog period after any reset is the long one.
// [R15] External timing counts fixed numbers of divided timebase clocks.
// [R16] External clock is divided by 64 before driving the watchdog.
// [R17] Backed-up output switches with the switchover comparator hysteresis.
// [R18] Backup-active is low on supply, high on battery.
// [R19] Early-warning out follows its comparator, forced low in backup.
// [R20] In backup, kick, chip-enable and timebase inputs are ignored.
// [R21] Comparator results are synchronised before use.
`timescale 1ns/10ps
`default_nettype none
`include "ssw_defs.vh"
module ssw_top #(
   parameter RST_CYC = `SSW_RST_CYC,
   parameter WD_LONG_CYC = `SSW_WD_LONG_CYC,
   parameter WD_SHORT_CYC = `SSW_WD_SHORT_CYC,
   parameter EXT_RST_TICKS = `SSW_EXT_RST_TICKS,
   parameter EXT_WD_TICKS = `SSW_EXT_WD_TICKS,
   parameter EXT_WD_LONG_TICKS = `SSW_EXT_WD_LONG_TICKS,
   parameter EXT_DIV = `SSW_EXT_DIV
) (
   input wire sys_clk,
   input wire resetn,
   input wire supply_good,
   input wire supply_above_batt,
   input wire early_warning_sense,
   input wire kick_input,
   input wire kick_float,
   input wire chip_enable_in_n,
   input wire timebase_select,
   input wire timebase_select_float,
   input wire timebase_input,
   output reg cpu_reset_n,
   output reg cpu_reset,
   output reg low_line_n,
   output reg kick_expired_n,
   output reg chip_enable_out_n,
   output reg backup_active,
   output reg early_warning_out_n,
   output reg main_power_switch,
   output reg backup_power_switch
);
   // ----------------------------------------------------------------
   // Comparator synchronisers
   // ----------------------------------------------------------------
   wire [2:0] cmp_sync;
   wire sup_ok;
   wire sw_main;
   wire ew_ok;
   ssw_sync #(.WIDTH(3), .INIT(3'h0)) u_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .async_in({early_warning_sense, supply_above_batt, supply_good}),
      .sync_out(cmp_sync)
   ); // [R21]
   assign sup_ok = cmp_sync[0];
   assign sw_main = cmp_sync[1];
   assign ew_ok = cmp_sync[2];

   // ----------------------------------------------------------------
   // External timebase divider
   // ----------------------------------------------------------------
   wire ext_tick;
   ssw_tick #(.DIV(EXT_DIV)) u_tick (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .ext_level(timebase_input),
      .ext_tick(ext_tick)
   ); // [R16]

   // ----------------------------------------------------------------
   // Mode and timeout choice
   // ----------------------------------------------------------------
   wire backup;
   wire line_ok;
   wire int_mode;
   wire step;
   assign backup = ~sw_main;
   // Supply under battery also counts as low line
   assign line_ok = sup_ok & sw_main; // [R1] [R5]
   // Select ignored in backup; nothing counts there anyway
   assign int_mode = timebase_select | timebase_select_float; // [R11]
   // Internal mode counts sys_clk cycles, external counts divided ticks
   assign step = int_mode ? 1'b1 : ext_tick; // [R15]

   reg first_period;
   reg [31:0] wd_limit;
   reg [31:0] rst_limit;
   always @* begin
      if (int_mode) begin
         rst_limit = RST_CYC; // [R12]
         if (first_period)
            wd_limit = WD_LONG_CYC; // [R14]
         else if (timebase_input)
            wd_limit = WD_LONG_CYC; // [R13]
         else
            wd_limit = WD_SHORT_CYC; // [R13]
      end else begin
         rst_limit = EXT_RST_TICKS; // [R15]
         if (first_period)
            wd_limit = EXT_WD_LONG_TICKS; // [R14]
         else
            wd_limit = EXT_WD_TICKS; // [R15]
      end
   end

   // ----------------------------------------------------------------
   // Kick edge detection
   // ----------------------------------------------------------------
   reg kick_prev;
   wire kick_edge;
   wire wd_on;
   // Floating kick input disables the watchdog; backup ignores it
   assign wd_on = ~kick_float & ~backup; // [R7] [R20]
   assign kick_edge = wd_on & (kick_input ^ kick_prev); // [R8]

   // ----------------------------------------------------------------
   // Reset pulse and watchdog state machine
   // ----------------------------------------------------------------
   localparam [2:0] ST_LOW = 3'h1;
   localparam [2:0] ST_PULSE = 3'h2;
   localparam [2:0] ST_RUN = 3'h4;

   reg [2:0] state;
   reg [31:0] rst_cnt;
   reg [31:0] wd_cnt;
   reg line_prev;
   wire wd_expire;
   assign wd_expire = wd_on & step & (wd_cnt + 32'h1 >= wd_limit);

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_LOW;
         rst_cnt <= 32'h0;
         wd_cnt <= 32'h0;
         first_period <= 1'b1;
         kick_prev <= 1'b0;
         line_prev <= 1'b0;
         cpu_reset_n <= 1'b0;
         cpu_reset <= 1'b1;
         kick_expired_n <= 1'b1;
      end else begin
         kick_prev <= kick_input;
         line_prev <= line_ok;
         case (state)
            ST_LOW: begin
               cpu_reset_n <= 1'b0; // [R1]
               cpu_reset <= 1'b1; // [R4]
               rst_cnt <= 32'h0;
               wd_cnt <= 32'h0;
               first_period <= 1'b1;
               if (line_ok)
                  state <= ST_PULSE; // [R2]
            end
            ST_PULSE: begin
               cpu_reset_n <= 1'b0;
               cpu_reset <= 1'b1; // [R4]
               wd_cnt <= 32'h0;
               first_period <= 1'b1; // [R14]
               if (!line_ok) begin
                  state <= ST_LOW;
               end else if (step) begin
                  if (rst_cnt + 32'h1 >= rst_limit) begin
                     state <= ST_RUN; // [R2] [R3]
                     cpu_reset_n <= 1'b1;
                     cpu_reset <= 1'b0;
                  end else begin
                     rst_cnt <= rst_cnt + 32'h1;
                  end
               end
            end
            ST_RUN: begin
               rst_cnt <= 32'h0;
               if (!line_ok) begin
                  state <= ST_LOW;
                  cpu_reset_n <= 1'b0; // [R1]
                  cpu_reset <= 1'b1;
               end else if (kick_edge || !wd_on) begin
                  wd_cnt <= 32'h0; // [R8]
               end else if (wd_expire) begin
                  // Pulse and restart: repeats once per timeout
                  state <= ST_PULSE; // [R3] [R6]
                  cpu_reset_n <= 1'b0;
                  cpu_reset <= 1'b1;
                  kick_expired_n <= 1'b0; // [R6]
                  wd_cnt <= 32'h0;
               end else if (step) begin
                  wd_cnt <= wd_cnt + 32'h1;
               end
               if (kick_edge)
                  first_period <= 1'b0;
            end
            default: begin
               state <= ST_LOW;
               cpu_reset_n <= 1'b0;
               cpu_reset <= 1'b1;
            end
         endcase
         // Release wins; also forced high in backup
         if (kick_edge || (line_prev && !line_ok) || backup)
            kick_expired_n <= 1'b1; // [R9] [R20]
         // A kick edge while held in pulse also returns the expiry flag high
         if (state == ST_PULSE && wd_on && !kick_expired_n && kick_edge)
            kick_expired_n <= 1'b1; // [R9]
      end
   end

   // ----------------------------------------------------------------
   // Status, chip-enable gate and power switches
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         low_line_n <= 1'b0;
         chip_enable_out_n <= 1'b1;
         backup_active <= 1'b1;
         early_warning_out_n <= 1'b0;
         main_power_switch <= 1'b0;
         backup_power_switch <= 1'b1;
      end else begin
         low_line_n <= line_ok; // [R5]
         // Register adds latency; the gate is forced high one cycle after line_ok falls
         chip_enable_out_n <= line_ok ? chip_enable_in_n : 1'b1; // [R10] [R20]
         main_power_switch <= sw_main; // [R17]
         backup_power_switch <= ~sw_main; // [R17]
         backup_active <= ~sw_main; // [R18]
         early_warning_out_n <= ew_ok & sw_main; // [R19]
      end
   end
endmodule
`default_nettype wire

// >>> test/ssw_host_model.sv
// Host processor model: kicks the watchdog or floats the kick line
`timescale 1ns/10ps
`default_nettype none
module ssw_host_model (
   input wire logic sys_clk,
   input wire logic run,
   input wire logic float_req,
   input wire logic [7:0] period,
   output logic kick_input,
   output logic kick_float
);
   logic [7:0] cnt = 8'h00;
   initial kick_input = 1'b0;
   initial kick_float = 1'b0;
   // Floating line wanders every cycle, so ignored edges really occur
   always @(posedge sys_clk) begin
      kick_float <= float_req;
      cnt <= (cnt >= period) ? 8'h00 : cnt + 8'h01;
      if (float_req || (run && cnt >= period))
         kick_input <= !kick_input;
   end
endmodule
`default_nettype wire

// >>> test/ssw_top_properties.sv
// Port assertions for the supervisor top level
`timescale 1ns/10ps
`default_nettype none
module ssw_props #(
   parameter RST_CYC = 20
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic supply_good,
   input wire logic supply_above_batt,
   input wire logic early_warning_sense,
   input wire logic kick_input,
   input wire logic kick_float,
   input wire logic chip_enable_in_n,
   input wire logic cpu_reset_n,
   input wire logic cpu_reset,
   input wire logic low_line_n,
   input wire logic kick_expired_n,
   input wire logic chip_enable_out_n,
   input wire logic backup_active,
   input wire logic early_warning_out_n
);
   wire line_ok = supply_good && supply_above_batt;
   int low_cnt;
   // Length of the current reset, to bound the pulse from below
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         low_cnt <= 0;
      else
         low_cnt <= cpu_reset_n ? 0 : low_cnt + 1;
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   // ---------------------------------------------
   // Checks; five-cycle windows cover the synchroniser
   // ---------------------------------------------
   chk_reset_inverse: assert property (
      cpu_reset == !cpu_reset_n) else $error("reset pair not inverse");
   chk_line_bad: assert property (
      (!line_ok)[*5] |-> !cpu_reset_n && !low_line_n && chip_enable_out_n)
      else $error("bad supply not flagged");
   chk_line_good: assert property (
      line_ok[*5] |-> low_line_n) else $error("low line stretched");
   chk_ce_pass: assert property (
      (line_ok && $stable(chip_enable_in_n))[*5]
      |-> chip_enable_out_n == chip_enable_in_n)
      else $error("chip enable not passed");
   chk_backup_outs: assert property (
      (!supply_above_batt)[*5]
      |-> backup_active && kick_expired_n && !early_warning_out_n)
      else $error("backup outputs wrong");
   chk_warn_follow: assert property (
      (supply_above_batt && $stable(early_warning_sense))[*5]
      |-> early_warning_out_n == early_warning_sense)
      else $error("warning output wrong");
   chk_pulse_min: assert property (
      $rose(cpu_reset_n) |-> low_cnt >= RST_CYC - 1)
      else $error("reset pulse short");
   chk_expiry_reset: assert property (
      $fell(kick_expired_n) |-> ##[0:3] !cpu_reset_n)
      else $error("expiry without reset");
   chk_kick_clears: assert property (
      !kick_expired_n && !kick_float && supply_above_batt
      && $changed(kick_input) |-> ##[1:4] kick_expired_n)
      else $error("kick did not clear expiry");
endmodule
bind ssw_top ssw_props #(.RST_CYC(RST_CYC)) u_props (.*);
`default_nettype wire

// >>> test/tb_ssw_top.sv
// Self-checking bench for the supervisor top level
`timescale 1ns/10ps
`default_nettype none
module tb_ssw_top;
   localparam int RC = 20;
   localparam int WL = 400;
   localparam int WS = 100;
   logic sys_clk = 1'b0, resetn = 1'b0, supply_good = 1'b0;
   logic supply_above_batt = 1'b1, early_warning_sense = 1'b1;
   logic chip_enable_in_n = 1'b1, timebase_select = 1'b1;
   logic timebase_select_float = 1'b0, timebase_input = 1'b0;
   logic run = 1'b1, float_req = 1'b0, ok;
   logic [7:0] period = 8'h14;
   logic [31:0] r;
   wire kick_input, kick_float, cpu_reset_n, cpu_reset, low_line_n;
   wire kick_expired_n, chip_enable_out_n, backup_active;
   wire early_warning_out_n, main_power_switch, backup_power_switch;
   int errors = 0, checks = 0, cyc = 0, n, t;
   ssw_top #(.RST_CYC(RC), .WD_LONG_CYC(WL), .WD_SHORT_CYC(WS),
      .EXT_RST_TICKS(2), .EXT_WD_TICKS(4), .EXT_WD_LONG_TICKS(6),
      .EXT_DIV(64)) u_dut (.*);
   ssw_host_model u_host (.*);
   always #12.5 sys_clk = !sys_clk;
   // ---------------------------------------------
   // Compare, wait and finish helpers
   // ---------------------------------------------
   task automatic chk(input string s, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s exp %b got %b", s, e, g);
      end
   endtask
   task automatic chk_n(input string s, input int lo, hi, g);
      checks++;
      if (g < lo || g > hi) begin
         errors++;
         $display("mismatch %s exp %0d..%0d got %0d", s, lo, hi, g);
      end
   endtask
   // Bounded wait: reset release (rst=1) or watchdog expiry (rst=0)
   task automatic until_ev(input bit rst, output int k);
      k = 0;
      do begin
         @(negedge sys_clk);
         k++;
      end while (k < 3000 && (rst ? cpu_reset_n !== 1'b1
                                  : kick_expired_n !== 1'b0));
      // A wait that runs out is a failure in its own right
      if (k >= 3000) begin
         errors++;
         $display("mismatch wait exp event got timeout");
      end
   endtask
   task automatic kick;
      run = 1'b1;
      @(negedge sys_clk);
      run = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk("kick clears", 1'b1, kick_expired_n);
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 12000) begin
         errors++;
         stop_test;
      end
   end
   initial begin
      r = $urandom(32'hb850);
      repeat (12) @(negedge sys_clk);
      chk("reset held", 1'b0, cpu_reset_n);
      resetn = 1'b1;
      supply_good = 1'b1;
      until_ev(1, n);
      chk_n("power-up pulse", RC, RC + 6, n);
      repeat (40) begin
         r = $urandom;
         supply_good = r[0] | r[1];
         supply_above_batt = r[2] | r[3];
         early_warning_sense = r[4];
         chip_enable_in_n = r[5];
         repeat (6) @(negedge sys_clk);
         ok = supply_good & supply_above_batt;
         chk("low_line_n", ok, low_line_n);
         chk("ce_out_n", ok ? r[5] : 1'b1, chip_enable_out_n);
         chk("backup", !r[2] & !r[3], backup_active);
         chk("main_sw", supply_above_batt, main_power_switch);
         chk("backup_sw", !supply_above_batt, backup_power_switch);
         chk("warn", r[4] & (r[2] | r[3]), early_warning_out_n);
         if (!ok) begin
            chk("cpu_reset_n", 1'b0, cpu_reset_n);
            chk("cpu_reset", 1'b1, cpu_reset);
         end
      end
      supply_good = 1'b0;
      supply_above_batt = 1'b1;
      run = 1'b0;
      repeat (6) @(negedge sys_clk);
      supply_good = 1'b1;
      until_ev(1, n);
      until_ev(0, n);
      chk_n("first period", WL - 2, WL + 10, n);
      repeat (3) @(negedge sys_clk);
      chk("wd reset", 1'b0, cpu_reset_n);
      period = 8'h00;
      // Second pass picks internal timing through a floating select pin
      for (int lv = 0; lv < 2; lv++) begin
         timebase_input = lv[0];
         timebase_select = !lv[0];
         timebase_select_float = lv[0];
         t = lv ? WL : WS;
         until_ev(1, n);
         kick;
         until_ev(0, n);
         chk_n("wd period", t - 2, t + 10, n + 5);
      end
      float_req = 1'b1;
      until_ev(1, n);
      repeat (2 * WL) @(negedge sys_clk);
      chk("float reset", 1'b1, cpu_reset_n);
      chk("float expiry", 1'b0, kick_expired_n);
      float_req = 1'b0;
      timebase_select = 1'b0;
      timebase_select_float = 1'b0;
      fork
         repeat (2000) @(negedge sys_clk) timebase_input = !timebase_input;
      join_none
      kick;
      until_ev(0, n);
      chk_n("ext period", 384, 660, n + 5);
      until_ev(1, n);
      chk_n("ext pulse", 128, 400, n);
      // Expiry flag is still low here, so wait on the reset pin instead
      n = 0;
      while (n < 3000 && cpu_reset_n === 1'b1) begin
         @(negedge sys_clk);
         n++;
      end
      chk_n("ext first period", 700, 800, n);
      stop_test;
   end
endmodule
`default_nettype wire
